// ---- dv/adc_bist_query_config_bench.sv ----
// Purpose: Self-checking bench for the config, ADC and self-test queries
// Assumes: Answer to a frame arrives in the following frame
// Notes:   Bench plays the converter and self-test engine itself
`timescale 1ns/10ps
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end
module adc_bist_query_config_bench;
    import adc_bist_query_pkg::*;

    logic              clk_in = 1'b0;
    logic              reset_n_in = 1'b0;
    logic              link_cs_n_in, link_clk_in, link_data_in;
    logic              link_data_out, link_data_oe_n_out;
    logic [1:0]        isns, tofs, auxos, aosel;
    logic              temp_rng, auxrng, conv_req_out;
    logic [SEL_W-1:0]  conv_sel_out;
    logic              conv_done_in = 1'b0;
    logic [SEL_W-1:0]  conv_done_sel_in = 4'h0;
    logic [DATA_W-1:0] conv_value_in = 10'h000;
    logic              self_test_running_in = 1'b0;
    logic              self_test_done_in = 1'b0;
    logic [DATA_W-1:0] self_test_result_in = 10'h000;
    logic [9:0]        cfg;
    logic [23:0]       rx;
    logic              drove;
    int                bad_count, checks, req_count;

    assign cfg = {isns, tofs, temp_rng, auxrng, auxos, aosel};

    always #5 clk_in = ~clk_in;

    // Count conversion starts to spot needless exchanges
    always @(posedge clk_in) begin
        if (conv_req_out === 1'b1) begin
            req_count <= req_count + 1;
        end
    end

    adc_bist_query_config u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .link_cs_n_in(link_cs_n_in),
        .link_clk_in(link_clk_in), .link_data_in(link_data_in), .link_data_out(link_data_out),
        .link_data_oe_n_out(link_data_oe_n_out), .temp_sense_current_sel_out(isns),
        .temp_offset_sel_out(tofs), .temp_range_sel_out(temp_rng), .aux_input_range_sel_out(auxrng),
        .aux_input_offset_sel_out(auxos), .analog_output_second_sel_out(aosel),
        .conv_req_out(conv_req_out), .conv_sel_out(conv_sel_out), .conv_done_in(conv_done_in),
        .conv_done_sel_in(conv_done_sel_in), .conv_value_in(conv_value_in),
        .self_test_running_in(self_test_running_in), .self_test_done_in(self_test_done_in),
        .self_test_result_in(self_test_result_in));

    link_host_model u_host (
        .clk_in(clk_in), .dev_data_in(link_data_out), .dev_oe_n_in(link_data_oe_n_out),
        .cs_n_out(link_cs_n_in), .lclk_out(link_clk_in), .ldata_out(link_data_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Counts: checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Judge one answer frame field by field
    task automatic ans(input logic [23:0] r, input logic [4:0] a, input logic [9:0] d);
        `CHK(r[23], 1'b0);
        `CHK(r[22:18], a);
        `CHK(r[17:8], d);
        `CHK(r[7:0], u_host.crc8({1'b0, a, d}));
    endtask : ans

    // Converter hands over one value
    task automatic conv_done(input logic [3:0] s, input logic [9:0] v);
        @(negedge clk_in);
        conv_done_in     = 1'b1;
        conv_done_sel_in = s;
        conv_value_in    = v;
        @(negedge clk_in);
        conv_done_in = 1'b0;
    endtask : conv_done

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK(cfg, 10'h300);
        `CHK(link_data_oe_n_out, 1'b1);
        u_host.send(1'b0, ADDR_CFG, 10'h000, rx, drove);
        ans(rx, ADDR_CFG, 10'h000);
    endtask : t_reset

    // Every code of every field, written on the fly
    task automatic t_config();
        logic [9:0] vals[4] = '{10'h155, 10'h2AA, 10'h3FF, 10'h000};
        for (int i = 0; i < 4; i++) begin
            u_host.send(1'b1, ADDR_CFG, vals[i], rx, drove);
            if (i == 0) begin
                ans(rx, ADDR_CFG, 10'h300);
            end
            `CHK(cfg, vals[i]);
        end
        u_host.send(1'b1, ADDR_CFG, 10'h2AA, rx, drove);
        u_host.send(1'b0, ADDR_CFG, 10'h000, rx, drove);
        u_host.send(1'b0, ADDR_CFG, 10'h000, rx, drove);
        ans(rx, ADDR_CFG, 10'h2AA);
    endtask : t_config

    // Miss then hit for each used source; unused codes and write refused
    task automatic t_adc();
        int n;
        for (int s = 0; s < 6; s++) begin
            n = req_count;
            // read frame with source in payload
            u_host.send(1'b0, ADDR_ADC, 10'(s), rx, drove);
            if (s > 0) begin
                ans(rx, ADDR_ADC, {6'h2C, 4'(s - 1)});
            end
            `CHK(req_count, n + 1);
            `CHK(conv_sel_out, 4'(s));
            conv_done(4'(s), {6'h2C, 4'(s)});
            u_host.send(1'b0, ADDR_ADC, 10'(s), rx, drove);
            ans(rx, ADDR_ADC, {6'h2C, 4'(s)});
            `CHK(req_count, n + 1);
        end
        n = req_count;
        u_host.send(1'b0, ADDR_ADC, 10'h006, rx, drove);
        ans(rx, ADDR_ADC, {6'h2C, 4'h5});
        u_host.send(1'b0, ADDR_ADC, 10'h00F, rx, drove);
        ans(rx, ADDR_ADC, 10'h000);
        u_host.send(1'b1, ADDR_ADC, 10'h002, rx, drove);
        ans(rx, ADDR_ADC, 10'h000);
        `CHK(req_count, n);
    endtask : t_adc

    // Results latched on completion, held, link quiet while running
    task automatic t_bist();
        @(negedge clk_in);
        self_test_result_in = 10'h201;
        self_test_done_in   = 1'b1;
        @(negedge clk_in);
        self_test_done_in   = 1'b0;
        self_test_result_in = 10'h0F0;
        u_host.send(1'b0, ADDR_BIST, 10'h000, rx, drove);
        ans(rx, ADDR_ADC, 10'h000);
        u_host.send(1'b0, ADDR_BIST, 10'h000, rx, drove);
        ans(rx, ADDR_BIST, 10'h201);
        self_test_running_in = 1'b1;
        u_host.send(1'b1, ADDR_CFG, 10'h155, rx, drove);
        `CHK(drove, 1'b0);
        `CHK(cfg, 10'h2AA);
        @(negedge clk_in);
        self_test_done_in = 1'b1;
        @(negedge clk_in);
        self_test_done_in    = 1'b0;
        self_test_running_in = 1'b0;
        u_host.send(1'b0, ADDR_BIST, 10'h000, rx, drove);
        ans(rx, ADDR_BIST, 10'h201);
        u_host.send(1'b0, ADDR_CFG, 10'h000, rx, drove);
        ans(rx, ADDR_BIST, 10'h0F0);
    endtask : t_bist

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset held four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_reset();
        t_config();
        t_adc();
        t_bist();
        tally_and_finish();
    end

    // Watchdog: the whole run needs well under 500 us
    initial begin
        #500000;
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

endmodule : adc_bist_query_config_bench

// ---- dv/link_host_model.sv ----
// Purpose: Host side of the serial link, sends one 24-bit frame per call
// Assumes: Link clock 80 ns period, idle low, runs only inside a frame
// Notes:   Reads the answer bit at each link clock rise
`timescale 1ns/10ps
module link_host_model
    import adc_bist_query_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic dev_data_in,
    input  wire logic dev_oe_n_in,
    output logic      cs_n_out,
    output logic      lclk_out,
    output logic      ldata_out
);

    // Idle link: deselected, clock parked low
    initial begin
        cs_n_out  = 1'b1;
        lclk_out  = 1'b0;
        ldata_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // check code generator
    function automatic logic [7:0] crc8(input logic [15:0] m);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ m[i]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8

    ////////////////////////////////////////////////////////////////////////
    // frame layout, MSB first
    task automatic send(input logic rw, input logic [4:0] a, input logic [9:0] d,
                        output logic [23:0] rx, output logic drove);
        logic [23:0] f;
        logic        last;
        f     = {rw, a, d, crc8({rw, a, d})};
        drove = 1'b0;
        last  = 1'b0;
        @(negedge clk_in);
        cs_n_out = 1'b0;
        // Keep every pin change on a falling clock edge
        #40;
        for (int i = 23; i >= 0; i--) begin
            ldata_out = f[i];
            #40;
            lclk_out = 1'b1;
            // Released line floats: read the inverse of the last bit
            if (dev_oe_n_in === 1'b0) begin
                rx[i] = dev_data_in;
                drove = 1'b1;
            end else begin
                rx[i] = ~last;
            end
            last = rx[i];
            #40;
            lclk_out = 1'b0;
        end
        #40;
        cs_n_out  = 1'b1;
        ldata_out = ~ldata_out;
        #80;
    endtask : send

endmodule : link_host_model

// ---- src/adc_bist_query_config.sv ----
// Purpose: Serial command handling for analog-output config, ADC query
//          and self-test result query
// Assumes: Link pins are asynchronous and sampled by clk_in
// Notes:   Answer to a frame is shifted out during the next frame
//
// Contract
// - Config register writable anytime, applied immediately; writes arriving during self-test are dropped
// - Sense current code, reset code 3
// - Temperature offset code, reset code 0
// - Temperature range bit, reset 5 V
// - Auxiliary range bit, reset 5 V
// - Auxiliary offset code, reset code 0
// - Analog output second selector, reset 0
// - ADC request converts when no value is stored for the source, and returns result
// - ADC request with write bit ignored
// - ADC answer carries address and value
// - Source codes 0-5 used, 6-15 unused
// - Self-test query answered with ten bits
// - Result bit zero pass, one fail
// - Self-test query answered in any mode; dropped during self-test or while a conversion is pending
// - Results held until new test completes
// - No link response during self-test
// - Result bit order nine down to zero
// - Stored value answered without new conversion
`timescale 1ns/10ps
module adc_bist_query_config
    import adc_bist_query_pkg::*;
#(
    parameter int STORE_DEPTH = 16
) (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              link_cs_n_in,
    input  wire logic              link_clk_in,
    input  wire logic              link_data_in,
    output logic                   link_data_out,
    output logic                   link_data_oe_n_out,
    output logic [1:0]             temp_sense_current_sel_out,
    output logic [1:0]             temp_offset_sel_out,
    output logic                   temp_range_sel_out,
    output logic                   aux_input_range_sel_out,
    output logic [1:0]             aux_input_offset_sel_out,
    output logic [1:0]             analog_output_second_sel_out,
    output logic                   conv_req_out,
    output logic [SEL_W-1:0]       conv_sel_out,
    input  wire logic              conv_done_in,
    input  wire logic [SEL_W-1:0]  conv_done_sel_in,
    input  wire logic [DATA_W-1:0] conv_value_in,
    input  wire logic              self_test_running_in,
    input  wire logic              self_test_done_in,
    input  wire logic [DATA_W-1:0] self_test_result_in
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [2:0]            sync1_reg;
    logic [2:0]            sync2_reg;
    logic [2:0]            prev_reg;
    logic                  cs_n;
    logic                  sck;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  link_ok;
    logic [CNT_W-1:0]      cnt_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic                  oe_n_reg;
    logic                  frame_done;
    logic                  rw;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     pay;
    logic [DATA_W-1:0]     cfg_reg;
    logic [DATA_W-1:0]     bist_reg;
    logic [STORE_DEPTH-1:0] valid_reg;
    req_state_type         state_reg;
    logic [SEL_W-1:0]      sel_reg;
    logic                  conv_req_reg;
    logic [ADDR_W-1:0]     resp_addr_reg;
    logic [DATA_W-1:0]     resp_data_reg;
    logic [FRAME_BITS-1:0] resp_word;
    logic [SEL_W-1:0]      rd_addr;
    logic [DATA_W-1:0]     rd_data;

    // Check code over flag, address and payload, MSB first
    function automatic logic [CRC_W-1:0] crc_of(input logic [15:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_of

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; edge logic compares the second stage with prev_reg
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sync1_reg <= PIN_IDLE;
            sync2_reg <= PIN_IDLE;
            prev_reg  <= PIN_IDLE;
        end else begin
            sync1_reg <= {link_cs_n_in, link_clk_in, link_data_in};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign cs_n     = sync2_reg[2];
    assign sck      = sync2_reg[1];
    assign sck_rise = sck & ~prev_reg[1];
    assign sck_fall = ~sck & prev_reg[1];
    assign cs_fall  = ~cs_n & prev_reg[2];
    assign cs_rise  = cs_n & ~prev_reg[2];
    assign link_ok  = ~self_test_running_in;

    ////////////////////////////////////////////////////////////////////
    // Receive shifter; over-long frames saturate and are dropped
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt_reg <= '0;
            rx_reg  <= '0;
        end else if (cs_fall) begin
            cnt_reg <= '0;
        end else if (sck_rise && !cs_n) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], sync2_reg[0]};
            if (cnt_reg != CNT_SAT) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    assign rw   = rx_reg[RW_POS];
    assign addr = rx_reg[ADDR_MSB:ADDR_LSB];
    assign pay  = rx_reg[DATA_MSB:DATA_LSB];
    assign frame_done = cs_rise && (cnt_reg == FRAME_CNT) && link_ok;

    ////////////////////////////////////////////////////////////////////
    // Transmit shifter: first bit shown at select, next on falling clock
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            tx_reg <= '0;
        end else if (cs_fall && link_ok) begin
            tx_reg <= resp_word;
        end else if (sck_fall && !cs_n) begin
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= cs_n | ~link_ok;
        end
    end

    assign link_data_out      = tx_reg[FRAME_BITS-1];
    assign link_data_oe_n_out = oe_n_reg;

    assign resp_word = {1'b0, resp_addr_reg, resp_data_reg,
                        crc_of({1'b0, resp_addr_reg, resp_data_reg})};

    ////////////////////////////////////////////////////////////////////
    // config write, no lock
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_reg <= CFG_RESET;
        end else if (frame_done && rw && addr == ADDR_CFG) begin
            cfg_reg <= pay;
        end
    end

    assign temp_sense_current_sel_out   = cfg_reg[ISNS_LSB+:2];
    assign temp_offset_sel_out          = cfg_reg[TOFS_LSB+:2];
    assign temp_range_sel_out           = cfg_reg[TEMP_RANGE_BIT];
    assign aux_input_range_sel_out      = cfg_reg[AUXRNG_BIT];
    assign aux_input_offset_sel_out     = cfg_reg[AUXOS_LSB+:2];
    assign analog_output_second_sel_out = cfg_reg[AOSEL_LSB+:2];

    ////////////////////////////////////////////////////////////////////
    // results held until done
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            bist_reg <= BIST_RESET;
        end else if (self_test_done_in) begin
            bist_reg <= self_test_result_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-source validity of the stored value
    for (genvar i = 0; i < STORE_DEPTH; i++) begin : g_valid
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                valid_reg[i] <= 1'b0;
            end else if (conv_done_in && conv_done_sel_in == SEL_W'(i)) begin
                valid_reg[i] <= 1'b1;
            end
        end
    end

    // Address the store from the frame while idle, saving a cycle
    assign rd_addr = (state_reg == ST_IDLE) ? pay[SEL_W-1:0] : sel_reg;

    conv_value_store #(
        .DEPTH (STORE_DEPTH),
        .AW    (SEL_W),
        .W     (DATA_W)
    ) u_store (
        .clk_in      (clk_in),
        .wr_en_in    (conv_done_in),
        .wr_addr_in  (conv_done_sel_in),
        .wr_data_in  (conv_value_in),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Read query handling; read frames arriving while busy are dropped
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_reg     <= ST_IDLE;
            sel_reg       <= SEL_REG_SUPPLY;
            conv_req_reg  <= 1'b0;
            resp_addr_reg <= ADDR_CFG;
            resp_data_reg <= '0;
        end else begin
            conv_req_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (frame_done && !rw) begin
                        if (addr == ADDR_CFG) begin
                            resp_addr_reg <= ADDR_CFG;
                            resp_data_reg <= cfg_reg;
                        end else if (addr == ADDR_BIST) begin
                            resp_addr_reg <= ADDR_BIST;
                            resp_data_reg <= bist_reg;
                        end else if (addr == ADDR_ADC) begin
                            resp_addr_reg <= ADDR_ADC;
                            sel_reg       <= pay[SEL_W-1:0];
                            if (pay[SEL_W-1:0] > SEL_LAST) begin
                                resp_data_reg <= '0;
                            end else if (valid_reg[pay[SEL_W-1:0]]) begin
                                state_reg <= ST_READ;
                            end else begin
                                conv_req_reg <= 1'b1;
                                state_reg    <= ST_CONV;
                            end
                        end
                    end
                end
                ST_READ: begin
                    resp_data_reg <= rd_data;
                    state_reg     <= ST_IDLE;
                end
                ST_CONV: begin
                    if (conv_done_in && conv_done_sel_in == sel_reg) begin
                        resp_data_reg <= conv_value_in;
                        state_reg     <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign conv_req_out = conv_req_reg;
    assign conv_sel_out = sel_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic adc_read;
    assign adc_read = frame_done && !rw && addr == ADDR_ADC && state_reg == ST_IDLE
                      && pay[SEL_W-1:0] <= SEL_LAST;

    sequence s_miss;
        adc_read && !valid_reg[pay[SEL_W-1:0]];
    endsequence
    sequence s_req_out;
        conv_req_out && state_reg == ST_CONV ##1 !conv_req_out;
    endsequence

    property p_cfg_write;
        frame_done && rw && addr == ADDR_CFG |=> cfg_reg == $past(pay);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_cfg_reset;
        $past(!reset_n_in) |-> temp_sense_current_sel_out == 2'h3 && temp_offset_sel_out == 2'h0
            && !temp_range_sel_out && !aux_input_range_sel_out && aux_input_offset_sel_out == 2'h0
            && analog_output_second_sel_out == 2'h0;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");

    property p_adc_write;
        frame_done && rw && addr == ADDR_ADC && state_reg == ST_IDLE |=> !conv_req_out
            && state_reg == ST_IDLE;
    endproperty
    a_adc_write: assert property (p_adc_write) else $error("write-flagged request acted on");

    property p_miss;
        s_miss |=> s_req_out;
    endproperty
    a_miss: assert property (p_miss) else $error("no conversion on miss");

    property p_hit;
        adc_read && valid_reg[pay[SEL_W-1:0]] |=> !conv_req_out [*2];
    endproperty
    a_hit: assert property (p_hit) else $error("stored value reconverted");

    property p_adc_answer;
        state_reg == ST_CONV && conv_done_in && conv_done_sel_in == sel_reg |=>
            resp_addr_reg == ADDR_ADC && resp_data_reg == $past(conv_value_in);
    endproperty
    a_adc_answer: assert property (p_adc_answer) else $error("conversion answer wrong");

    property p_bist_hold;
        !self_test_done_in |=> $stable(bist_reg);
    endproperty
    a_bist_hold: assert property (p_bist_hold) else $error("self-test result changed");

    property p_bist_answer;
        frame_done && !rw && addr == ADDR_BIST && state_reg == ST_IDLE |=>
            resp_addr_reg == ADDR_BIST && resp_data_reg == bist_reg;
    endproperty
    a_bist_answer: assert property (p_bist_answer) else $error("self-test answer wrong");

    property p_test_quiet;
        self_test_running_in |=> link_data_oe_n_out && !frame_done;
    endproperty
    a_test_quiet: assert property (p_test_quiet) else $error("link active during test");

endmodule : adc_bist_query_config

// ---- src/adc_bist_query_pkg.sv ----
// Purpose: Shared constants for the ADC / self-test query block
// Assumes: 24-bit frames, MSB first
// Notes:   Check code polynomial and seed are plain defaults
package adc_bist_query_pkg;

    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_W     = 5;
    localparam int DATA_W     = 10;
    localparam int CRC_W      = 8;
    localparam int SEL_W      = 4;
    localparam int CNT_W      = 5;
    localparam int RW_POS     = 23;
    localparam int ADDR_MSB   = 22;
    localparam int ADDR_LSB   = 18;
    localparam int DATA_MSB   = 17;
    localparam int DATA_LSB   = 8;
    localparam logic [CNT_W-1:0] FRAME_CNT = 5'h18;
    localparam logic [CNT_W-1:0] CNT_SAT   = 5'h1F;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_CFG  = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_ADC  = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_BIST = 5'h14;

    // Configuration field positions and reset value
    localparam int ISNS_LSB   = 8;
    localparam int TOFS_LSB   = 6;
    localparam int TEMP_RANGE_BIT = 5;
    localparam int AUXRNG_BIT = 4;
    localparam int AUXOS_LSB  = 2;
    localparam int AOSEL_LSB  = 0;
    localparam logic [DATA_W-1:0] CFG_RESET  = 10'h300;
    localparam logic [DATA_W-1:0] BIST_RESET = 10'h000;

    // Conversion source codes; 6 to 15 unused
    localparam logic [SEL_W-1:0] SEL_REG_SUPPLY = 4'h0;
    localparam logic [SEL_W-1:0] SEL_AUX    = 4'h1;
    localparam logic [SEL_W-1:0] SEL_VPOS   = 4'h2;
    localparam logic [SEL_W-1:0] SEL_VNEG   = 4'h3;
    localparam logic [SEL_W-1:0] SEL_PWRT   = 4'h4;
    localparam logic [SEL_W-1:0] SEL_DIET   = 4'h5;
    localparam logic [SEL_W-1:0] SEL_LAST   = SEL_DIET;

    // Check code generator
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h2F;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'hFF;

    // Pin synchroniser idle level: select high, clock low, data low
    localparam logic [2:0] PIN_IDLE = 3'h4;

    typedef enum {ST_IDLE, ST_READ, ST_CONV} req_state_type;

endpackage : adc_bist_query_pkg

// ---- src/conv_value_store.sv ----
// Purpose: Small store of the latest conversion value per source
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered, one cycle after the address
`timescale 1ns/10ps
module conv_value_store #(
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int W     = 10
) (
    input  wire logic          clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [W-1:0]  wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [W-1:0]  rd_data_out
);

    logic [W-1:0] mem_reg [DEPTH];

    // Write port; contents need no reset, validity lives outside
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read
    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_reg[rd_addr_in];
    end

endmodule : conv_value_store
